/* File: verilog/flash_host_pkg.sv */
// Constants and types shared by the parallel flash host controller
`default_nettype none
package flash_host_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 25;
   localparam int unsigned RECOVERY_NS     = 430;
   localparam int unsigned RECOVERY_CYC    = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WORD_ADDR_W     = 13;
   localparam int unsigned BLOCK_ADDR_W    = 5;
   localparam int unsigned ADDR_W          = WORD_ADDR_W + BLOCK_ADDR_W;
   localparam int unsigned LANE_W          = 8;
   localparam int unsigned DATA_W          = 2 * LANE_W;
   localparam int unsigned WORD_LSB        = 0;
   localparam int unsigned BLOCK_LSB       = WORD_ADDR_W;
   localparam int unsigned BUS_SETUP_CYC   = 2;
   localparam int unsigned STROBE_CYC      = 3;
   localparam int unsigned READ_CYC        = 4;
   localparam int unsigned HOLD_CYC        = 1;
   localparam logic [7:0]  CMD_READ_ARRAY  = 8'hFF;
   localparam int unsigned CNT_W           = 6;
   localparam logic [CNT_W-1:0] CNT_ONE    = 6'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO   = 6'h00;

   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_POWERDOWN} op_t;
endpackage : flash_host_pkg
`default_nettype wire

/* File: verilog/flash_pin_if.sv */
// Interface carrying the flash pin group between the sequencer and the pin driver
`default_nettype none
interface flash_pin_if;
   import flash_host_pkg::*;
   logic                    ce_n;
   logic                    oe_n;
   logic                    we_n;
   logic                    rst_n;
   logic                    wide;
   logic                    byte_lane_select;
   logic [ADDR_W-1:0]       addr;
   logic [DATA_W-1:0]       wdata;
   logic                    drive_low;
   logic                    drive_high;

   modport seq (output ce_n, oe_n, we_n, rst_n, wide, byte_lane_select, addr, wdata,
                drive_low, drive_high);
   modport pins (input ce_n, oe_n, we_n, rst_n, wide, byte_lane_select, addr, wdata,
                 drive_low, drive_high);
endinterface : flash_pin_if
`default_nettype wire

/* File: verilog/flash_pin_drive.sv */
// Pin driver: maps sequencer controls onto flash address, control and data pins
`default_nettype none
module flash_pin_drive
   import flash_host_pkg::*;
(
   flash_pin_if.pins                 ctl,
   output logic                      chip_sel_n,
   output logic                      out_gate_n,
   output logic                      write_strobe_n,
   output logic                      powerdown_reset_n,
   output logic                      width_select,
   output logic [WORD_ADDR_W-1:0]    word_select_addr,
   output logic [BLOCK_ADDR_W-1:0]   block_select_addr,
   output logic [LANE_W-1:0]         low_data_lane_o,
   output logic                      low_data_lane_oe,
   output logic [LANE_W-2:0]         high_data_lane_o,
   output logic                      high_data_lane_oe,
   output logic                      byte_lane_select_o,
   output logic                      byte_lane_select_oe
);
   // Control and address pins
   assign chip_sel_n        = ctl.ce_n;
   assign out_gate_n        = ctl.oe_n;
   assign write_strobe_n    = ctl.we_n;
   assign powerdown_reset_n = ctl.rst_n;
   assign width_select      = ctl.wide;
   assign word_select_addr  = ctl.addr[WORD_LSB +: WORD_ADDR_W];
   assign block_select_addr = ctl.addr[BLOCK_LSB +: BLOCK_ADDR_W];

   // Data lanes; top pin of the high lane doubles as byte select in narrow mode
   assign low_data_lane_o     = ctl.wdata[LANE_W-1:0];
   assign low_data_lane_oe    = ctl.drive_low;                 // [RULE6]
   assign high_data_lane_o    = ctl.wdata[DATA_W-2:LANE_W];
   assign high_data_lane_oe   = ctl.drive_high;
   assign byte_lane_select_o  = ctl.wide ? ctl.wdata[DATA_W-1] : ctl.byte_lane_select;
   assign byte_lane_select_oe = ctl.wide ? ctl.drive_high : !ctl.rst_n ? 1'b0 : 1'b1;
endmodule : flash_pin_drive
`default_nettype wire

/* File: verilog/flash_host_ctrl.sv */
// Host controller that drives a parallel flash through its pins
// How it works
// RULE1 - Narrow mode: byte_lane_select picks high or low byte of the word.
// RULE2 - Narrow writes hold byte_lane_select stable with address across the strobe.
// RULE3 - Wide mode drives width_select high; byte select pin carries data only.
// RULE4 - word_select_addr picks a word in a block, stable through writes.
// RULE5 - block_select_addr picks one of 32 blocks, stable through writes.
// RULE6 - Commands and data go out on low lane; reads sample low lane.
// RULE7 - Device floats lanes when deselected or output gate inactive.
// RULE8 - High lane driven only in wide writes; status reads ignore it.
// RULE9 - Chip select held low for the whole of each access.
// RULE10 - Power-down request holds powerdown_reset_n low, aborting device work.
// RULE11 - After releasing power-down, wait 430 ns before any access.
// RULE12 - Device status clears on power-down; host tracks nothing stale.
// RULE13 - Device leaves power-down in read-array mode.
// RULE14 - powerdown_reset_n held low through reset and power transitions.
// RULE15 - Address and data stable around the rising write strobe edge.
// RULE16 - Host never drives lanes while output gate is low.
// RULE17 - busy_indicator_n low means engine busy; sampled and reported.
// RULE18 - width_select low selects narrow mode on the low lane only.
`default_nettype none
module flash_host_ctrl
   import flash_host_pkg::*;
#(
   parameter int unsigned RECOVERY_CYCLES = flash_host_pkg::RECOVERY_CYC
)(
   input  wire logic                                sys_clk,
   input  wire logic                                srst,
   input  wire logic                                req_valid,
   output logic                                     req_ready,
   input  wire flash_host_pkg::op_t                 req_op,
   input  wire logic                                req_wide,
   input  wire logic [flash_host_pkg::ADDR_W-1:0]   req_addr,
   input  wire logic                                req_byte_hi,
   input  wire logic [flash_host_pkg::DATA_W-1:0]   req_wdata,
   input  wire logic                                req_status,
   output logic                                     rsp_valid,
   output logic [flash_host_pkg::DATA_W-1:0]        rsp_rdata,
   output logic                                     powered_down,
   output logic                                     engine_busy,
   output logic                                     chip_sel_n,
   output logic                                     out_gate_n,
   output logic                                     write_strobe_n,
   output logic                                     powerdown_reset_n,
   output logic                                     width_select,
   output logic [flash_host_pkg::WORD_ADDR_W-1:0]   word_select_addr,
   output logic [flash_host_pkg::BLOCK_ADDR_W-1:0]  block_select_addr,
   output logic [flash_host_pkg::LANE_W-1:0]        low_data_lane_o,
   output logic                                     low_data_lane_oe,
   input  wire logic [flash_host_pkg::LANE_W-1:0]   low_data_lane_i,
   output logic [flash_host_pkg::LANE_W-2:0]        high_data_lane_o,
   output logic                                     high_data_lane_oe,
   input  wire logic [flash_host_pkg::LANE_W-2:0]   high_data_lane_i,
   output logic                                     byte_lane_select_o,
   output logic                                     byte_lane_select_oe,
   input  wire logic                                byte_lane_select_i,
   input  wire logic                                busy_indicator_n
);
   import flash_host_pkg::*;

   initial
   begin
      if (RECOVERY_CYCLES < 1 || RECOVERY_CYCLES >= (1 << CNT_W))
         $error("RECOVERY_CYCLES out of counter range");
   end

   // ----------------------------------------------------------------
   // Sequencer state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {S_DOWN, S_RECOVER, S_IDLE, S_SETUP, S_STROBE, S_READ,
                             S_HOLD} state_t;

   state_t                  state_q, state_d;
   logic [CNT_W-1:0]        cnt_q, cnt_d;
   op_t                     op_q;
   logic                    wide_q;
   logic                    byte_hi_q;
   logic                    status_q;
   logic [ADDR_W-1:0]       addr_q;
   logic [DATA_W-1:0]       wdata_q;
   logic [DATA_W-1:0]       rdata_q;
   logic                    rsp_q;
   logic                    busy_q;
   logic                    down_req_q;

   flash_pin_if pin_bus ();

   // Request decode
   wire take      = req_valid && req_ready;
   wire take_down = take && req_op == OP_POWERDOWN;
   wire cnt_done  = cnt_q == CNT_ONE;
   wire is_write  = op_q == OP_WRITE;
   wire in_access = state_q inside {S_SETUP, S_STROBE, S_READ, S_HOLD};

   // Read lane assembly: narrow and status reads use only the low lane
   wire [LANE_W-1:0] hi_sample = {byte_lane_select_i, high_data_lane_i};
   wire [DATA_W-1:0] rd_word   = (wide_q && !status_q) ? {hi_sample, low_data_lane_i}
                                                        : {{LANE_W{1'b0}}, low_data_lane_i};

   assign req_ready = (state_q == S_IDLE) || (state_q == S_DOWN);

   // Next-state logic
   always_comb
   begin
      state_d = state_q;
      cnt_d   = (cnt_q == CNT_ZERO) ? CNT_ZERO : cnt_q - CNT_ONE;
      unique case (state_q)
         S_DOWN:
         begin
            if (take && req_op != OP_POWERDOWN)
            begin
               state_d = S_RECOVER;                              // [RULE11]
               cnt_d   = RECOVERY_CYCLES[CNT_W-1:0];
            end
         end
         S_RECOVER:
            if (cnt_done)
               state_d = S_SETUP;
         S_IDLE:
         begin
            if (take_down)
               state_d = S_DOWN;                                 // [RULE10]
            else if (take)
            begin
               state_d = S_SETUP;
               cnt_d   = BUS_SETUP_CYC[CNT_W-1:0];
            end
         end
         S_SETUP:
         begin
            if (cnt_done || cnt_q == CNT_ZERO)
            begin
               state_d = is_write ? S_STROBE : S_READ;
               cnt_d   = is_write ? STROBE_CYC[CNT_W-1:0] : READ_CYC[CNT_W-1:0];
            end
         end
         S_STROBE, S_READ:
         begin
            if (cnt_done)
            begin
               state_d = S_HOLD;                                 // [RULE15]
               cnt_d   = HOLD_CYC[CNT_W-1:0];
            end
         end
         S_HOLD:
            if (cnt_done)
               state_d = S_IDLE;
      endcase
   end

   // State and counter registers
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_q <= S_DOWN;                                      // [RULE14]
         cnt_q   <= CNT_ZERO;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= (state_q == S_RECOVER && cnt_done) ? BUS_SETUP_CYC[CNT_W-1:0] : cnt_d;
      end
   end

   // Request capture; address and lane select held for the whole access
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         op_q      <= OP_READ;
         wide_q    <= 1'b0;
         byte_hi_q <= 1'b0;
         status_q  <= 1'b0;
         addr_q    <= '0;
         wdata_q   <= '0;
      end
      else if (take && !take_down)
      begin
         op_q      <= req_op;
         wide_q    <= req_wide;                                  // [RULE3] [RULE18]
         byte_hi_q <= req_byte_hi;                               // [RULE1] [RULE2]
         status_q  <= req_status;
         addr_q    <= req_addr;                                  // [RULE4] [RULE5]
         wdata_q   <= req_wdata;
      end
   end

   // Read data and response strobe
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rdata_q <= '0;
         rsp_q   <= 1'b0;
      end
      else
      begin
         rsp_q <= state_q == S_HOLD && cnt_done;
         if (state_q == S_READ && cnt_done)
            rdata_q <= rd_word;                                  // [RULE6] [RULE8]
      end
   end

   // Busy indicator sampling and power-down request flag
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         busy_q     <= 1'b0;
         down_req_q <= 1'b1;
      end
      else
      begin
         busy_q     <= !busy_indicator_n && powerdown_reset_n;   // [RULE17]
         down_req_q <= state_d == S_DOWN;                        // [RULE12] [RULE13]
      end
   end

   assign rsp_valid    = rsp_q;
   assign rsp_rdata    = rdata_q;
   assign engine_busy  = busy_q;
   assign powered_down = down_req_q;

   // ----------------------------------------------------------------
   // Pin controls
   // ----------------------------------------------------------------
   assign pin_bus.rst_n            = state_q != S_DOWN;          // [RULE10] [RULE14]
   assign pin_bus.ce_n             = !in_access;                 // [RULE9]
   assign pin_bus.oe_n             = state_q != S_READ;          // [RULE7] [RULE16]
   assign pin_bus.we_n             = !(state_q == S_STROBE);
   assign pin_bus.wide             = wide_q;
   assign pin_bus.byte_lane_select = byte_hi_q;
   assign pin_bus.addr             = addr_q;
   assign pin_bus.wdata            = wdata_q;
   assign pin_bus.drive_low        = in_access && is_write;      // [RULE6] [RULE16]
   assign pin_bus.drive_high       = in_access && is_write && wide_q;   // [RULE8]

   flash_pin_drive u_pins (
      .ctl                 (pin_bus),
      .chip_sel_n          (chip_sel_n),
      .out_gate_n          (out_gate_n),
      .write_strobe_n      (write_strobe_n),
      .powerdown_reset_n   (powerdown_reset_n),
      .width_select        (width_select),
      .word_select_addr    (word_select_addr),
      .block_select_addr   (block_select_addr),
      .low_data_lane_o     (low_data_lane_o),
      .low_data_lane_oe    (low_data_lane_oe),
      .high_data_lane_o    (high_data_lane_o),
      .high_data_lane_oe   (high_data_lane_oe),
      .byte_lane_select_o  (byte_lane_select_o),
      .byte_lane_select_oe (byte_lane_select_oe)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_no_bus_fight: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE16]
      !out_gate_n |-> !low_data_lane_oe && !high_data_lane_oe)
      else $error("host drives data while output gate low");
   // Cycles since the device was woken, saturating; feeds the recovery check
   logic [CNT_W-1:0]        wake_cnt_q;
   always_ff @(posedge sys_clk)
   begin
      if (srst || !powerdown_reset_n)
         wake_cnt_q <= CNT_ZERO;
      else if (wake_cnt_q != '1)
         wake_cnt_q <= wake_cnt_q + CNT_ONE;
   end
   a_recovery_wait: assert property (@(posedge sys_clk) disable iff (srst) // [RULE11]
      !chip_sel_n |-> wake_cnt_q >= RECOVERY_CYCLES[CNT_W-1:0])
      else $error("access before recovery time");
   a_strobe_ce: assert property (@(posedge sys_clk) disable iff (srst)     // [RULE9]
      !write_strobe_n |-> !chip_sel_n)
      else $error("write strobe without chip select");
   a_addr_stable: assert property (@(posedge sys_clk) disable iff (srst)   // [RULE15]
      $rose(write_strobe_n) |-> $stable(word_select_addr) && $stable(block_select_addr)
         && !chip_sel_n)
      else $error("address moved at strobe rise");
   a_hi_lane_wide: assert property (@(posedge sys_clk) disable iff (srst)  // [RULE8]
      high_data_lane_oe |-> width_select && !chip_sel_n && out_gate_n)
      else $error("high lane driven in narrow mode");
   a_down_no_ce: assert property (@(posedge sys_clk) disable iff (srst)    // [RULE10]
      !powerdown_reset_n |-> chip_sel_n && write_strobe_n)
      else $error("access during power-down");
   a_strobe_len: assert property (@(posedge sys_clk) disable iff (srst)    // [RULE2]
      $fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n)
      else $error("write strobe width wrong");
   a_byte_sel: assert property (@(posedge sys_clk) disable iff (srst)      // [RULE1]
      !chip_sel_n && !$past(chip_sel_n) && !width_select
         |-> byte_lane_select_oe && $stable(byte_lane_select_o))
      else $error("byte select not held during narrow access");
endmodule : flash_host_ctrl
`default_nettype wire

/* File: dv/flash_dev_model.sv */
// Behavioural model of the parallel flash device seen by the host controller
`default_nettype none
module flash_dev_model
#(
   parameter int BUSY_NS     = 2000,
   parameter int RECOVERY_NS = 430
)(
   input  wire logic        chip_sel_n,
   input  wire logic        out_gate_n,
   input  wire logic        write_strobe_n,
   input  wire logic        powerdown_reset_n,
   input  wire logic        width_select,
   input  wire logic [12:0] word_select_addr,
   input  wire logic [4:0]  block_select_addr,
   input  wire logic [7:0]  low_in,
   input  wire logic [6:0]  high_in,
   input  wire logic        bls_in,
   output logic [7:0]       low_out,
   output logic             low_oe,
   output logic [6:0]       high_out,
   output logic             high_oe,
   output logic             bls_out,
   output logic             bls_oe,
   output logic             busy_pull,
   output int               early_count
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [0:262143];
   logic [15:0] word;
   logic        active;
   realtime     wake_t;

   // ----------------------------------------------
   // Read path
   // ----------------------------------------------
   // Lanes driven only while selected, gated and awake; reads always show array data
   assign word = mem[{block_select_addr, word_select_addr}];
   assign active = !chip_sel_n && !out_gate_n && powerdown_reset_n;
   assign low_oe = active;
   assign high_oe = active && width_select;
   assign bls_oe = high_oe;
   assign low_out = (!width_select && bls_in) ? word[15:8] : word[7:0];
   assign {bls_out, high_out} = word[15:8];

   // Erased array, engine idle
   initial
   begin
      busy_pull = 1'b0;
      early_count = 0;
      wake_t = 0.0;
      for (int i = 0; i < 262144; i++) mem[i] = 16'hffff;
   end

   // ----------------------------------------------
   // Write path and engine
   // ----------------------------------------------
   // Address and data latched on the rising write strobe; engine then runs a while
   always @(posedge write_strobe_n)
   begin
      if (chip_sel_n === 1'b0 && powerdown_reset_n === 1'b1)
      begin
         if (width_select) mem[{block_select_addr, word_select_addr}] = {bls_in, high_in, low_in};
         else if (bls_in) mem[{block_select_addr, word_select_addr}][15:8] = low_in;
         else mem[{block_select_addr, word_select_addr}][7:0] = low_in;
         busy_pull = 1'b1;
         fork
            begin
               #(BUSY_NS);
               busy_pull = 1'b0;
            end
         join_none
      end
   end

   // Power-down aborts the engine and clears its state
   always @(negedge powerdown_reset_n) busy_pull = 1'b0;

   // Any selection while asleep or too soon after waking is counted
   always @(posedge powerdown_reset_n) wake_t = $realtime;
   always @(negedge chip_sel_n)
   begin
      if (powerdown_reset_n !== 1'b1 || $realtime - wake_t < RECOVERY_NS) early_count++;
   end
endmodule : flash_dev_model
`default_nettype wire

/* File: dv/tb_flash_host_ctrl.sv */
// Self-checking testbench for the parallel flash host controller
`default_nettype none
module tb_flash_host_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   import flash_host_pkg::*;
   logic        sys_clk = 1'b0;
   logic        srst, req_valid, req_ready, req_wide, req_byte_hi, req_status, rsp_valid;
   logic        powered_down, engine_busy, chip_sel_n, out_gate_n, write_strobe_n;
   logic        powerdown_reset_n, width_select, low_data_lane_oe, high_data_lane_oe;
   logic        byte_lane_select_o, byte_lane_select_oe, byte_lane_select_i, busy_indicator_n;
   logic        cur_wide, cur_bhi, flip, dev_low_oe, dev_high_oe, dev_bls, dev_bls_oe, dev_busy;
   op_t         req_op;
   logic [17:0] req_addr, cur_addr, a;
   logic [15:0] req_wdata, rsp_rdata, d;
   logic [12:0] word_select_addr;
   logic [4:0]  block_select_addr;
   logic [7:0]  low_data_lane_o, low_data_lane_i, dev_low;
   logic [6:0]  high_data_lane_o, high_data_lane_i, dev_high;
   logic [15:0] ref_mem [int];
   int          seed, early_count;
   int          bad_count = 0;
   int          checked = 0;

   // ----------------------------------------------
   // Clock, pins and instances
   // ----------------------------------------------
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) flip <= ~flip;

   // Resolved pin levels; an undriven lane toggles every cycle, busy line pulled up
   assign low_data_lane_i = low_data_lane_oe ? low_data_lane_o : dev_low_oe ? dev_low : {8{flip}};
   assign high_data_lane_i = high_data_lane_oe ? high_data_lane_o
                           : dev_high_oe ? dev_high : {7{flip}};
   assign byte_lane_select_i = byte_lane_select_oe ? byte_lane_select_o
                             : dev_bls_oe ? dev_bls : flip;
   assign busy_indicator_n = ~dev_busy;

   flash_host_ctrl #(.RECOVERY_CYCLES(RECOVERY_CYC)) flash_host_ctrl_i (
      .sys_clk, .srst, .req_valid, .req_ready, .req_op, .req_wide, .req_addr, .req_byte_hi,
      .req_wdata, .req_status, .rsp_valid, .rsp_rdata, .powered_down, .engine_busy,
      .chip_sel_n, .out_gate_n, .write_strobe_n, .powerdown_reset_n, .width_select,
      .word_select_addr, .block_select_addr, .low_data_lane_o, .low_data_lane_oe,
      .low_data_lane_i, .high_data_lane_o, .high_data_lane_oe, .high_data_lane_i,
      .byte_lane_select_o, .byte_lane_select_oe, .byte_lane_select_i, .busy_indicator_n);

   flash_dev_model flash_dev_model_i (
      .chip_sel_n, .out_gate_n, .write_strobe_n, .powerdown_reset_n, .width_select,
      .word_select_addr, .block_select_addr, .low_in(low_data_lane_i),
      .high_in(high_data_lane_i), .bls_in(byte_lane_select_i), .low_out(dev_low),
      .low_oe(dev_low_oe), .high_out(dev_high), .high_oe(dev_high_oe), .bls_out(dev_bls),
      .bls_oe(dev_bls_oe), .busy_pull(dev_busy), .early_count);

   // ----------------------------------------------
   // Checking and request tasks
   // ----------------------------------------------
   task automatic fail(input string msg);
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask : fail

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) fail($sformatf("got %h expected %h", seen, exp));
   endtask : check

   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   // One request, held until taken; reads compared with the reference array
   task automatic access(input op_t op, input logic wide, input logic [17:0] ad,
                         input logic bhi, input logic [15:0] wd, input logic st);
      int          n;
      logic [15:0] w;
      n = 0;
      w = ref_mem.exists(ad) ? ref_mem[ad] : 16'hffff;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_op <= op;
      {req_wide, req_addr, req_byte_hi, req_wdata, req_status} <= {wide, ad, bhi, wd, st};
      {cur_wide, cur_addr, cur_bhi} <= {wide, ad, bhi};
      @(negedge sys_clk);
      while (req_ready !== 1'b1 && n < 100)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 100) fail("request not taken");
      @(posedge sys_clk);
      req_valid <= 1'b0;
      if (op == OP_POWERDOWN) return;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while (rsp_valid !== 1'b1 && n < 200);
      if (n >= 200) fail("no response");
      if (op == OP_WRITE) ref_mem[ad] = wide ? wd : bhi ? {wd[7:0], w[7:0]} : {w[15:8], wd[7:0]};
      else check(rsp_rdata, st ? {8'h00, w[7:0]} : wide ? w
                 : {8'h00, bhi ? w[15:8] : w[7:0]});
   endtask : access

   // Pin watch during every access
   always @(negedge sys_clk)
   begin
      if (srst === 1'b0 && chip_sel_n === 1'b0)
      begin
         check({11'h0, block_select_addr}, {11'h0, cur_addr[17:13]});
         check({3'h0, word_select_addr}, {3'h0, cur_addr[12:0]});
         check({15'h0, width_select}, {15'h0, cur_wide});
         if (!cur_wide) check({15'h0, byte_lane_select_o & byte_lane_select_oe},
                              {15'h0, cur_bhi});
         check({12'h0, ~out_gate_n & low_data_lane_oe, ~out_gate_n & high_data_lane_oe,
                ~out_gate_n & width_select & byte_lane_select_oe,
                ~cur_wide & high_data_lane_oe}, 16'h0000);
      end
   end

   // ----------------------------------------------
   // Scenarios
   // ----------------------------------------------
   initial
   begin
      seed = 89;
      srst = 1'b1;
      req_valid = 1'b0;
      req_op = OP_READ;
      {req_wide, req_addr, req_byte_hi, req_wdata, req_status} = '0;
      {cur_wide, cur_addr, cur_bhi, flip} = '0;
      repeat (9) @(posedge sys_clk);
      @(negedge sys_clk);
      check({13'h0, powerdown_reset_n, chip_sel_n, powered_down}, 16'h0003);
      @(posedge sys_clk);
      srst <= 1'b0;
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         a = (i == 0) ? 18'h0_0000 : (i == 1) ? 18'h3_ffff : 18'($random(seed));
         d = 16'($random(seed));
         access(OP_WRITE, 1'b1, a, 1'b0, d, 1'b0);
         access(OP_READ, 1'b1, a, 1'b0, 16'h0000, 1'b0);
      end
      $display("test wide done");
      a = 18'($random(seed));
      d = 16'($random(seed));
      access(OP_WRITE, 1'b0, a, 1'b1, d, 1'b0);
      access(OP_WRITE, 1'b0, a, 1'b0, ~d, 1'b0);
      access(OP_READ, 1'b0, a, 1'b1, 16'h0000, 1'b0);
      access(OP_READ, 1'b0, a, 1'b0, 16'h0000, 1'b0);
      access(OP_READ, 1'b1, a, 1'b0, 16'h0000, 1'b0);
      access(OP_READ, 1'b1, a, 1'b0, 16'h0000, 1'b1);
      $display("test narrow done");
      access(OP_WRITE, 1'b1, a, 1'b0, d, 1'b0);
      repeat (3) @(negedge sys_clk);
      check({15'h0, engine_busy}, 16'h0001);
      access(OP_POWERDOWN, 1'b1, a, 1'b0, 16'h0000, 1'b0);
      repeat (2) @(negedge sys_clk);
      check({13'h0, powered_down, powerdown_reset_n, engine_busy}, 16'h0004);
      access(OP_READ, 1'b1, a, 1'b0, 16'h0000, 1'b0);
      check({15'h0, engine_busy}, 16'h0000);
      check(early_count[15:0], 16'h0000);
      $display("test powerdown done");
      close_out();
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      #(20000 * 25);
      fail("watchdog expired");
      close_out();
   end
endmodule : tb_flash_host_ctrl
`default_nettype wire
